// ==== rtl/lte_device.sv ====
// Transmit front end of the line interface: sampling, line coding, clock loss watch
//
// Functional notes
// - Driver enabled when hiz input low
// - Control mode from two select pins
// - Serial mode uses edge select input
// - Host sets standard bit for T1/J1
// - Hardware mode: pulse pins give standard
// - Framer supplies 2.048 or 1.544 MHz clock
// - Clock absent over 70 cycles raises loss
// - Sample on configured transmit clock edge
// - Software selects data inversion
// - Hardware mode: falling edge, active high
// - Rail select picks single or dual
// - T1 single rail: B8ZS or AMI
// - E1 single rail: HDB3 or AMI
// - Dual rail bypasses the encoder
// - Dual rail maps rails to pulses
// - Hardware mode: path mode from pins
// - Host programs E1 pulse codes
// - T1 has five preset pulse templates
// - Host programs J1 pulse code
`timescale 1ns/1ps
`include "lte_map.svh"
module lte_device (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  lte_if.device           pins,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [1:0] path_mode,
  output logic      [3:0] template_sel,
  output logic            serial_edge
);
  logic [7:0] gcf_reg;
  logic [7:0] tx_interface_config_reg;
  logic [7:0] tx_pulse_config_reg;
  lte_pkg::lte_ctrl_mode_t mode_reg;
  logic       clk_d_reg;
  logic [7:0] mclk_div_reg;
  logic [7:0] idle_cnt_reg;
  logic       loss_reg;
  logic       p_reg, n_reg, oe_reg;
  logic       last_pos_reg;
  logic [3:0] zero_run_reg;
  logic [7:0] hist_reg;
  logic [7:0] hold_reg;
  logic       marks_odd_reg;
  logic       t1_mode, hw_mode, rail_dual, use_sub, inv, fall_edge;
  logic       sample_en, mclk_en, bit_in, dn_in;
  logic [7:0] hw_bits;

  always_ff @(posedge sys_clk) begin
    if (!rstn)
      mode_reg <= lte_pkg::LTE_CTRL_HW;
    else
      unique case ({pins.ctrl_sel_hi, pins.ctrl_sel_lo})
        2'h0: mode_reg <= lte_pkg::LTE_CTRL_HW;
        2'h1: mode_reg <= lte_pkg::LTE_CTRL_SERIAL;
        2'h2: mode_reg <= lte_pkg::LTE_CTRL_MUX_M;
        2'h3: mode_reg <= lte_pkg::LTE_CTRL_MUX_I;
      endcase
  end
  assign hw_mode = (mode_reg == lte_pkg::LTE_CTRL_HW);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      gcf_reg  <= `LTE_RST_GLOBAL_CONFIG;
      tx_interface_config_reg <= `LTE_RST_TX_INTERFACE_CFG;
      tx_pulse_config_reg <= `LTE_RST_TX_PULSE_CFG;
    end else if (reg_wr) begin
      if (reg_addr == `LTE_OFF_GLOBAL_CONFIG) gcf_reg <= reg_wdata;
      if (reg_addr == `LTE_OFF_TX_INTERFACE_CFG) tx_interface_config_reg <= reg_wdata;
      if (reg_addr == `LTE_OFF_TX_PULSE_CFG) tx_pulse_config_reg <= reg_wdata;
    end
  end

  assign hw_bits = {2'h0, pins.path_mode_sel, pins.pulse_sel};
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      unique case (reg_addr)
        `LTE_OFF_GLOBAL_CONFIG:    reg_rdata <= gcf_reg;
        `LTE_OFF_TX_INTERFACE_CFG: reg_rdata <= tx_interface_config_reg;
        `LTE_OFF_TX_PULSE_CFG:     reg_rdata <= tx_pulse_config_reg;
        `LTE_OFF_TX_STATUS:        reg_rdata <= {7'h00, loss_reg};
        `LTE_OFF_HW_PINS:          reg_rdata <= hw_bits;
        default:                   reg_rdata <= 8'h00;
      endcase
    else
      reg_rdata <= 8'h00;
  end

  // Hardware mode: pulse codes above E1 select T1/J1
  assign t1_mode = hw_mode ? (pins.pulse_sel > `LTE_PULS_E1_120)
                           : gcf_reg[`LTE_BIT_STANDARD_SEL];
  assign rail_dual = hw_mode ? 1'b0 : tx_interface_config_reg[`LTE_BIT_RAIL_SEL];
  assign use_sub = hw_mode ? 1'b1 : tx_interface_config_reg[`LTE_BIT_ENCODER_SEL];
  assign inv = hw_mode ? 1'b0 : tx_interface_config_reg[`LTE_BIT_DATA_INVERT];
  assign fall_edge = hw_mode ? 1'b1 : ~tx_interface_config_reg[`LTE_BIT_EDGE_SEL];

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      path_mode    <= 2'h0;
      template_sel <= 4'h0;
      serial_edge  <= 1'b0;
    end else begin
      path_mode    <= hw_mode ? pins.path_mode_sel : 2'h0;
      template_sel <= hw_mode ? pins.pulse_sel : tx_pulse_config_reg[3:0];
      serial_edge  <= (mode_reg == lte_pkg::LTE_CTRL_SERIAL) & pins.serial_edge_sel;
    end
  end

  // Transmit clock is taken as synchronous; edges are found by comparison
  always_ff @(posedge sys_clk) begin
    if (!rstn) clk_d_reg <= 1'b0;
    else clk_d_reg <= pins.tx_clk;
  end
  assign sample_en = fall_edge ? (clk_d_reg & ~pins.tx_clk)
                               : (~clk_d_reg & pins.tx_clk);

  always_ff @(posedge sys_clk) begin
    if (!rstn || mclk_div_reg == `LTE_MCLK_DIV - 8'h01) mclk_div_reg <= 8'h00;
    else mclk_div_reg <= mclk_div_reg + 8'h01;
  end
  assign mclk_en = (mclk_div_reg == `LTE_MCLK_DIV - 8'h01);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      idle_cnt_reg <= 8'h00;
      loss_reg     <= 1'b0;
    end else if (clk_d_reg != pins.tx_clk) begin
      idle_cnt_reg <= 8'h00;
      loss_reg     <= 1'b0;
    end else if (mclk_en) begin
      if (idle_cnt_reg != `LTE_TXCLK_LOSS_CYCLES) idle_cnt_reg <= idle_cnt_reg + 8'h01;
      else loss_reg <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) pins.txclk_loss <= 1'b0;
    else pins.txclk_loss <= loss_reg & ~tx_interface_config_reg[`LTE_BIT_LOSS_MASK];
  end

  assign bit_in = pins.tx_data_pos ^ inv;
  assign dn_in  = pins.tx_data_neg ^ inv;

  // Single rail: a 4-bit delay lets HDB3/B8ZS rewrite zero runs before emission.
  // B8ZS decides on the eighth zero, when its first three have already left as spaces
  logic [3:0] pend_reg;
  logic [7:0] kind_reg;
  logic [3:0] pend_next;
  logic [7:0] kind_next;
  logic [1:0] emit;
  logic       odd_next;
  logic       hdb3_hit, b8zs_hit;
  always_comb begin
    emit      = kind_reg[7:6];
    pend_next = {pend_reg[2:0], bit_in};
    kind_next = {kind_reg[5:0], bit_in ? 2'h1 : 2'h0};
    // Parity must include the symbol leaving now, or back-to-back runs pick the wrong form
    odd_next  = (emit == 2'h3) ? 1'b0 : ((emit != 2'h0) ? ~marks_odd_reg : marks_odd_reg);
    hdb3_hit  = ~t1_mode & use_sub & (pend_next == 4'h0) & (zero_run_reg[1:0] == 2'h0)
                & (kind_reg[5:0] == 6'h00);
    b8zs_hit  = t1_mode & use_sub & ({hist_reg[6:0], bit_in} == 8'h00)
                & (hold_reg[6:0] == 7'h00);
    if (hdb3_hit)
      kind_next = odd_next ? 8'h03 : 8'h83; // 000V or B00V
    if (b8zs_hit)
      kind_next = 8'h00;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_reg <= 4'h0; kind_reg <= 8'h00; hist_reg <= 8'h00; hold_reg <= 8'h00;
      zero_run_reg <= 4'h0; last_pos_reg <= 1'b0; marks_odd_reg <= 1'b0;
      p_reg <= 1'b0; n_reg <= 1'b0;
    end else if (sample_en) begin
      if (rail_dual) begin
        p_reg <= dn_in & ~bit_in;
        n_reg <= bit_in & ~dn_in;
      end else begin
        pend_reg <= pend_next;
        hist_reg <= {hist_reg[6:0], bit_in};
        hold_reg <= b8zs_hit ? 8'h01 : {hold_reg[6:0], 1'b0};
        kind_reg <= kind_next;
        zero_run_reg <= hdb3_hit ? 4'h1 : {zero_run_reg[2:0], 1'b0};
        // B8ZS 000VB0VB: V now, then B, space, V, B from the hold shift
        if (b8zs_hit || hold_reg[2]) begin // V
          p_reg <= last_pos_reg; n_reg <= ~last_pos_reg;
        end else if (hold_reg[0] || hold_reg[3]) begin // B
          p_reg <= ~last_pos_reg; n_reg <= last_pos_reg; last_pos_reg <= ~last_pos_reg;
        end else if (emit == 2'h3) begin // HDB3 violation
          p_reg <= last_pos_reg; n_reg <= ~last_pos_reg; marks_odd_reg <= 1'b0;
        end else if (emit[0] || emit == 2'h2) begin
          p_reg <= ~last_pos_reg; n_reg <= last_pos_reg; last_pos_reg <= ~last_pos_reg;
          marks_odd_reg <= ~marks_odd_reg;
        end else begin
          p_reg <= 1'b0; n_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pins.line_tx_p  <= 1'b0;
      pins.line_tx_n  <= 1'b0;
      pins.line_tx_oe <= 1'b0;
    end else begin
      pins.line_tx_p  <= p_reg;
      pins.line_tx_n  <= n_reg;
      pins.line_tx_oe <= ~pins.driver_hiz_in;
    end
  end
endmodule

// ==== include/lte_map.svh ====
// Register offsets, field positions and timing counts of the transmit front end
`ifndef LTE_MAP_SVH
`define LTE_MAP_SVH
`define LTE_OFF_GLOBAL_CONFIG     8'h02
`define LTE_OFF_TX_INTERFACE_CFG  8'h05
`define LTE_OFF_TX_PULSE_CFG      8'h06
`define LTE_OFF_TX_STATUS         8'h0f
`define LTE_OFF_HW_PINS           8'h10
`define LTE_BIT_STANDARD_SEL      0
`define LTE_BIT_ENCODER_SEL       0
`define LTE_BIT_RAIL_SEL          1
`define LTE_BIT_DATA_INVERT       2
`define LTE_BIT_EDGE_SEL          3
`define LTE_BIT_LOSS_MASK         4
`define LTE_RST_GLOBAL_CONFIG     8'h00
`define LTE_RST_TX_INTERFACE_CFG  8'h00
`define LTE_RST_TX_PULSE_CFG      8'h00
`define LTE_MCLK_DIV              8'h05
`define LTE_TXCLK_LOSS_CYCLES     8'h46
`define LTE_PULS_E1_120           4'h1
`define LTE_PULS_J1               4'h7
`define LTE_PULS_T1_LAST          4'h6
`define LTE_PULS_T1_FIRST         4'h2
`endif

// ==== include/lte_pkg.sv ====
// Types used by the line end of the transmit front end
package lte_pkg;
  typedef enum logic [3:0] {
    LTE_CTRL_HW     = 4'h1,
    LTE_CTRL_SERIAL = 4'h2,
    LTE_CTRL_MUX_M  = 4'h4,
    LTE_CTRL_MUX_I  = 4'h8
  } lte_ctrl_mode_t;
  typedef enum logic [1:0] {
    LTE_SYM_SPACE = 2'h0,
    LTE_SYM_POS   = 2'h1,
    LTE_SYM_NEG   = 2'h2
  } lte_sym_t;
endpackage

// ==== include/lte_if.sv ====
// Pins between the framer and the line interface transmit front end
`timescale 1ns/1ps
interface lte_if;
  logic       tx_clk;
  logic       tx_data_pos;
  logic       tx_data_neg;
  logic       driver_hiz_in;
  logic       ctrl_sel_hi;
  logic       ctrl_sel_lo;
  logic       serial_edge_sel;
  logic [3:0] pulse_sel;
  logic [1:0] path_mode_sel;
  logic       line_tx_p;
  logic       line_tx_n;
  logic       line_tx_oe;
  logic       txclk_loss;
  modport device (
    input  tx_clk, tx_data_pos, tx_data_neg, driver_hiz_in, ctrl_sel_hi, ctrl_sel_lo,
    input  serial_edge_sel, pulse_sel, path_mode_sel,
    output line_tx_p, line_tx_n, line_tx_oe, txclk_loss
  );
  modport host (
    output tx_clk, tx_data_pos, tx_data_neg, driver_hiz_in, ctrl_sel_hi, ctrl_sel_lo,
    output serial_edge_sel, pulse_sel, path_mode_sel,
    input  line_tx_p, line_tx_n, line_tx_oe, txclk_loss
  );
endinterface

// ==== rtl/lte_host.sv ====
// Framer end: makes the transmit clock and drives data and strap pins
`timescale 1ns/1ps
`include "lte_map.svh"
module lte_host (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  lte_if.host             pins,
  input  wire logic       e1_mode,
  input  wire logic [7:0] half_period,
  input  wire logic       data_pos,
  input  wire logic       data_neg,
  input  wire logic       hiz,
  input  wire logic [1:0] ctrl_sel,
  input  wire logic       serial_edge,
  input  wire logic [3:0] pulse_code,
  input  wire logic [1:0] path_mode,
  input  wire logic       clk_run,
  output logic            bit_taken,
  output logic            loss_seen
);
  logic [7:0] div_reg;
  logic       tick;
  // Divider toggles tx_clk every half_period + 1 cycles while clk_run is high; half_period sets the rate, clk_run stops it
  assign tick = (div_reg == half_period);
  always_ff @(posedge sys_clk) begin
    if (!rstn || tick) div_reg <= 8'h00;
    else div_reg <= div_reg + 8'h01;
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pins.tx_clk <= 1'b0;
      pins.tx_data_pos <= 1'b0;
      pins.tx_data_neg <= 1'b0;
      bit_taken <= 1'b0;
    end else begin
      bit_taken <= 1'b0;
      if (tick && clk_run) begin
        pins.tx_clk <= ~pins.tx_clk;
        if (!pins.tx_clk) begin // Change data on rising edge, stable at falling
          pins.tx_data_pos <= data_pos;
          pins.tx_data_neg <= data_neg;
          bit_taken <= 1'b1;
        end
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pins.driver_hiz_in <= 1'b1;
      pins.ctrl_sel_hi <= 1'b0;
      pins.ctrl_sel_lo <= 1'b0;
      pins.serial_edge_sel <= 1'b0;
      pins.pulse_sel <= 4'h0;
      pins.path_mode_sel <= 2'h0;
      loss_seen <= 1'b0;
    end else begin
      pins.driver_hiz_in <= hiz;
      {pins.ctrl_sel_hi, pins.ctrl_sel_lo} <= ctrl_sel;
      pins.serial_edge_sel <= serial_edge;
      // E1 codes at or below 120 ohm; when not E1 every code passes unchanged
      pins.pulse_sel <= (e1_mode && pulse_code > `LTE_PULS_E1_120) ? `LTE_PULS_E1_120
                                                                  : pulse_code;
      pins.path_mode_sel <= path_mode;
      loss_seen <= pins.txclk_loss;
    end
  end
endmodule

// ==== test/lte_properties.sv ====
// Checker on the pins joining the framer end and the line end
`timescale 1ns/1ps
module lte_properties (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tx_clk,
  input wire logic driver_hiz_in,
  input wire logic line_tx_p,
  input wire logic line_tx_n,
  input wire logic line_tx_oe,
  input wire logic txclk_loss
);
  logic       tx_clk_reg;
  logic [9:0] quiet_reg;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  always_ff @(posedge sys_clk) begin
    tx_clk_reg <= tx_clk;
  end
  // Saturates so a long stop never wraps back into the early window
  always_ff @(posedge sys_clk) begin
    if (!rstn || tx_clk != tx_clk_reg) begin
      quiet_reg <= 10'h000;
    end else if (quiet_reg != 10'h3ff) begin
      quiet_reg <= quiet_reg + 10'h001;
    end
  end
  sequence hiz_held;
    driver_hiz_in [*3];
  endsequence
  sequence edge_in_loss;
    txclk_loss && tx_clk != tx_clk_reg;
  endsequence
  oe_off_a: assert property (hiz_held |-> !line_tx_oe)
    else $error("driver on while hiz");
  oe_on_a: assert property (!driver_hiz_in [*3] |-> line_tx_oe)
    else $error("driver off");
  one_polarity_a: assert property (!(line_tx_p && line_tx_n))
    else $error("both polarities");
  idle_frozen_a: assert property (quiet_reg > 10'h014 |-> $stable({line_tx_p, line_tx_n}))
    else $error("symbol without clock");
  loss_early_a: assert property ($rose(txclk_loss) |-> quiet_reg >= 10'h154)
    else $error("loss too early");
  loss_clear_a: assert property (edge_in_loss |-> ##[1:20] !txclk_loss)
    else $error("loss not cleared");
  loss_fall_a: assert property ($fell(txclk_loss) |-> quiet_reg <= 10'h014)
    else $error("loss fell without edge");
  loss_hold_a: assert property (txclk_loss && quiet_reg > 10'h014 |=> txclk_loss)
    else $error("loss dropped");
endmodule

// ==== test/test_lineiface_tx_front_end.sv ====
// Bench joining the framer end and the line end of the transmit front end
`timescale 1ns/1ps
module test_lineiface_tx_front_end;
  logic       sys_clk, rstn, reg_wr, reg_rd, e1_mode, data_pos, data_neg, hiz;
  logic       serial_edge, sedge_out, clk_run, bit_taken, loss_seen;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, half_period;
  logic [3:0] pulse_code, template_sel;
  logic [1:0] ctrl_sel, path_mode, path_out;
  int         failures, n_compared;
  lte_if pins ();
  lte_device lte_device_i (.sys_clk(sys_clk), .rstn(rstn), .pins(pins.device),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .path_mode(path_out), .template_sel(template_sel),
    .serial_edge(sedge_out));
  lte_host lte_host_i (.sys_clk(sys_clk), .rstn(rstn), .pins(pins.host), .e1_mode(e1_mode),
    .half_period(half_period), .data_pos(data_pos), .data_neg(data_neg), .hiz(hiz),
    .ctrl_sel(ctrl_sel), .serial_edge(serial_edge), .pulse_code(pulse_code),
    .path_mode(path_mode), .clk_run(clk_run), .bit_taken(bit_taken), .loss_seen(loss_seen));
  lte_properties lte_properties_i (.sys_clk(sys_clk), .rstn(rstn), .tx_clk(pins.tx_clk),
    .driver_hiz_in(pins.driver_hiz_in), .line_tx_p(pins.line_tx_p),
    .line_tx_n(pins.line_tx_n), .line_tx_oe(pins.line_tx_oe), .txclk_loss(pins.txclk_loss));
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk("rdata", reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  // One symbol per launched bit, read at a fixed offset so each bit is seen once
  task automatic bit_sym(output logic [1:0] s);
    int k;
    for (k = 0; k < 100 && bit_taken !== 1'b1; k++) begin
      @(posedge sys_clk);
    end
    if (k == 100) begin
      failures++;
      tally_and_finish();
    end else begin
      @(negedge sys_clk);
      s = {pins.line_tx_p, pins.line_tx_n};
      @(posedge sys_clk);
    end
  endtask
  task automatic s_regs();
    rd(8'h02, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    wr(8'h02, 8'h01);
    wr(8'h06, 8'h07);
    rd(8'h02, 8'h01);
    rd(8'h06, 8'h07);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    chk("template", {4'h0, template_sel}, 8'h07);
  endtask
  task automatic s_pins();
    hiz <= 1'b0;
    path_mode <= 2'h2;
    serial_edge <= 1'b1;
    pulse_code <= 4'h5;
    for (int m = 0; m < 4; m++) begin
      ctrl_sel <= m[1:0];
      cyc(6);
      chk("path", {6'h00, path_out}, (m == 0) ? 8'h02 : 8'h00);
      if (m == 1) chk("sedge", {7'h00, sedge_out}, 8'h01);
      if (m == 0) chk("tmpl", {4'h0, template_sel}, 8'h05);
    end
    chk("oe", {7'h00, pins.line_tx_oe}, 8'h01);
    rd(8'h10, 8'h25);
    e1_mode <= 1'b1;
    ctrl_sel <= 2'h0;
    cyc(6);
    chk("e1 tmpl", {4'h0, template_sel}, 8'h01);
    e1_mode <= 1'b0;
    hiz <= 1'b1;
    cyc(6);
    chk("oe", {7'h00, pins.line_tx_oe}, 8'h00);
    ctrl_sel <= 2'h1;
    cyc(2);
  endtask
  task automatic s_dual();
    logic [1:0] s, e;
    for (int i = 0; i < 8; i++) begin
      wr(8'h05, {4'h0, i[1], i[2], 1'b1, i[0]});
      data_pos <= i[0];
      data_neg <= i[1];
      repeat (6) bit_sym(s);
      e = i[1:0] ^ {2{i[2]}};
      chk("dual", {6'h00, s}, {6'h00, e[1] & ~e[0], e[0] & ~e[1]});
    end
  endtask
  // Idle line: substitution alone must put marks on it, and the run length tells the code
  task automatic s_code();
    logic [1:0] s, last;
    int         marks, run, longest;
    data_neg <= 1'b1;
    data_pos <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, {7'h00, i[1]});
      wr(8'h05, {7'h00, i[0]});
      marks = 0;
      run = 0;
      longest = 0;
      repeat (16) bit_sym(s);
      for (int b = 0; b < 16; b++) begin
        bit_sym(s);
        marks += (s != 2'h0);
        run = (s == 2'h0) ? run + 1 : 0;
        longest = (run > longest) ? run : longest;
      end
      chk("marks", 8'(marks), i[0] ? 8'h08 : 8'h00);
      chk("zero run", 8'(longest), i[0] ? (i[1] ? 8'h03 : 8'h02) : 8'h10);
    end
    wr(8'h05, 8'h00);
    data_pos <= 1'b1;
    last = 2'h3;
    marks = 0;
    repeat (8) bit_sym(s);
    for (int b = 0; b < 8; b++) begin
      bit_sym(s);
      marks += (s == last || s == 2'h0);
      last = s;
    end
    chk("ami repeat", 8'(marks), 8'h00);
  endtask
  task automatic s_loss();
    clk_run <= 1'b0;
    cyc(300);
    chk("loss", {7'h00, pins.txclk_loss}, 8'h00);
    cyc(120);
    chk("loss", {7'h00, pins.txclk_loss}, 8'h01);
    chk("loss seen", {7'h00, loss_seen}, 8'h01);
    clk_run <= 1'b1;
    cyc(40);
    chk("loss", {7'h00, pins.txclk_loss}, 8'h00);
    wr(8'h05, 8'h10);
    clk_run <= 1'b0;
    cyc(420);
    chk("masked", {7'h00, pins.txclk_loss}, 8'h00);
    rd(8'h0f, 8'h01);
    clk_run <= 1'b1;
    cyc(40);
    rd(8'h0f, 8'h00);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    failures = 0;
    n_compared = 0;
    rstn = 1'b0;
    {reg_wr, reg_rd, data_pos, data_neg, serial_edge, e1_mode} = 6'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    {hiz, clk_run} = 2'h3;
    half_period = 8'h07;
    ctrl_sel = 2'h1;
    path_mode = 2'h0;
    pulse_code = 4'h0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    s_regs();
    s_pins();
    s_dual();
    s_code();
    s_loss();
    tally_and_finish();
  end
endmodule
